// ==== inc/fsc_pkg.sv ====
// shared constants and carrier types for the clock supervisor
package fsc_pkg;

  // ==========================================================================
  // sample clock divider
  localparam int unsigned LF_DIV_RATIO = 64;                 // lf osc periods per sample period
  localparam int unsigned LF_HALF_DIV  = LF_DIV_RATIO / 2;   // lf edges per sample half period
  localparam int unsigned DIV_W        = $clog2(LF_HALF_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LF_HALF_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_RST  = '0;

  // ==========================================================================
  // osc control register layout
  localparam int unsigned OSC_CTRL_W     = 8;
  localparam int unsigned SCS_LSB        = 0;   // clock_source_select [1:0]
  localparam int unsigned PRIMARY_RUN_MODE_BIT    = 3;   // primary_running_status
  localparam int unsigned IFS_LSB        = 4;   // internal_freq_select [6:4]
  localparam logic [1:0]  SCS_RST        = 2'h0;
  localparam logic [2:0]  IFS_RST        = 3'h3;

  // peripheral irq flags 2 layout
  localparam int unsigned IRQ2_W         = 8;
  localparam int unsigned OSC_FAIL_BIT   = 7;

  // clock_source_select encodings
  localparam logic [1:0]  SCS_PRIMARY    = 2'h0;
  localparam logic [1:0]  SCS_SECONDARY  = 2'h1;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    FSC_SRC_PRIMARY,
    FSC_SRC_SECONDARY,
    FSC_SRC_INTERNAL
  } fsc_src_t;

  typedef enum logic [1:0] {
    FSC_ST_START,      // running from internal while primary starts
    FSC_ST_RUN,        // running from the selected source, monitored
    FSC_ST_FAILSAFE    // monitored source lost, internal fallback
  } fsc_state_t;

  // static configuration fuses
  typedef struct packed {
    logic monitor_config_enable;
    logic dual_speed_start_enable;
    logic pri_is_crystal;           // crystal/resonator primary, needs start-up timers
  } fsc_cfg_t;

  // software write into the osc control register
  typedef struct packed {
    logic       wr;
    logic [1:0] clock_source_select;
    logic [2:0] internal_freq_select;
  } fsc_ctrl_wr_t;

  // power management events
  typedef struct packed {
    logic wake;        // power-on reset done or sleep exit, one-cycle pulse
    logic pm_entry;    // entry into a power-managed mode, one-cycle pulse
    logic idle;        // cpu is in idle
  } fsc_pm_t;

endpackage : fsc_pkg

// ==== hw/fsc_edge_sync.sv ====
// two-stage synchroniser with edge pulses taken after the second stage
`timescale 1ns/10ps
module fsc_edge_sync (
  // clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  // raw level
  input  wire logic D,
  // synchronised level and edges
  output logic      Q,
  output logic      RISE,
  output logic      FALL
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // ==========================================================================
  // only sync_q reads meta_q, so a metastable sample never reaches the edges
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= D;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // edges from stable stages only
  assign Q    = sync_q;
  assign RISE = sync_q & ~last_q;
  assign FALL = ~sync_q & last_q;

endmodule : fsc_edge_sync

// ==== hw/fsc_monitor.sv ====
// clock failure monitor, start-up masking and clock source sequencing
`timescale 1ns/10ps
//
// Contract
// RULE1: with monitor enabled, sample clock is low-freq osc divided by 64.
// RULE2: monitor latch set by device clock fall, cleared by sample clock rise.
// RULE3: at each sample clock fall, a still-set latch declares clock failure.
// RULE4: failure sets osc fail flag, bit 7 of peripheral irq flags 2.
// RULE5: failure switches to internal osc; control register keeps old source.
// RULE6: failure resets the watchdog counter and postscaler.
// RULE7: monitor enable keeps the low-freq oscillator running continuously.
// RULE8: only primary or secondary sources are monitored, never the internal one.
// RULE9: watchdog disable does not stop the oscillator while monitoring is enabled.
// RULE10: fail-safe ends only on device reset or power-managed mode entry.
// RULE11: after reset run internal until primary ready, then switch, set status.
// RULE12: primary never ready: stay internal, register keeps reset value.
// RULE13: power-managed entry selects register source and resumes monitoring.
// RULE14: failure in power-managed mode: internal clock, no automatic return.
// RULE15: fail interrupt disabled: idle wake-ups execute on internal osc.
// RULE16: non-crystal primary: monitoring starts right after reset or wake; with dual-speed start enabled, code waits for primary ready.
// RULE17: crystal primary: internal clock until start-up timers expire, then monitor.
// RULE18: primary never starting raises no fail flag; status bit shows it.
// RULE19: power-managed entry while waiting for primary disables the primary; code keeps it enabled when the register selects primary.
// RULE20: status bit 3 reads 1 when primary clocks the device, else 0.
// RULE21: during dual-speed start, source select writes and sleep are accepted.
// RULE22: dual-speed start runs internal, switching to primary at timer expiry.
// RULE23: fail flag sticky until software clears it, registered for the cpu.
module fsc_monitor
  import fsc_pkg::*;
(
  // clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST_N,
  // configuration fuses
  input  wire fsc_pkg::fsc_cfg_t     CFG,
  // oscillator levels and readiness
  input  wire logic                  LF_OSC,       // low_freq_internal_osc output
  input  wire logic                  DEV_CLK,      // monitored device clock
  input  wire logic                  PRI_READY,    // osc_startup_timer and pll expired
  // software access
  input  wire fsc_pkg::fsc_ctrl_wr_t CTRL_WR,
  input  wire logic                  FLAG_CLR,     // clear osc_fail_flag, pulse
  input  wire logic                  FAIL_IE,      // fail interrupt enable
  input  wire logic                  WDT_EN,
  // power management
  input  wire fsc_pkg::fsc_pm_t      PM,
  // clock steering
  output fsc_pkg::fsc_src_t          CLK_SEL,
  output logic                       PRI_OSC_EN,
  output logic                       LF_OSC_EN,
  output logic                       EXEC_ON_INT,
  // status
  output logic [OSC_CTRL_W-1:0]      OSC_CTRL,
  output logic [IRQ2_W-1:0]          IRQ_FLAGS2,
  output logic                       FAIL_SAFE,
  output logic                       WDT_RST
);

  // ==========================================================================
  // declarations
  fsc_state_t       state_q, state_d;
  logic [DIV_W-1:0] div_q;
  logic             sample_clk_q;
  logic             samp_rise;
  logic             samp_fall;
  logic             latch_q;
  logic             fail_evt;
  logic             flag_q;
  logic             wdt_rst_q;
  logic             pri_en_q;
  logic [1:0]       scs_q;
  logic [2:0]       ifs_q;
  logic             lf_q;
  logic             lf_rise;
  logic             dev_fall;
  logic             mon_active;
  logic             start_masked;
  fsc_src_t         sel_src;

  // map the source select field to a mux source
  function automatic fsc_src_t scs_to_src(input logic [1:0] scs);
    if (scs == SCS_PRIMARY) begin
      scs_to_src = FSC_SRC_PRIMARY;
    end else if (scs == SCS_SECONDARY) begin
      scs_to_src = FSC_SRC_SECONDARY;
    end else begin
      scs_to_src = FSC_SRC_INTERNAL;
    end
  endfunction : scs_to_src

  // ==========================================================================
  // input synchronisers
  fsc_edge_sync u_lf_sync (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .D       (LF_OSC),
    .Q       (lf_q),
    .RISE    (lf_rise),
    .FALL    ()
  );

  fsc_edge_sync u_dev_sync (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .D       (DEV_CLK),
    .Q       (),
    .RISE    (),
    .FALL    (dev_fall)
  );

  // ==========================================================================
  // oscillator enables
  // the watchdog has its own divider, so it only adds to the enable
  assign LF_OSC_EN = CFG.monitor_config_enable | WDT_EN; // RULE7 RULE9

  // ==========================================================================
  // sample clock: toggles every 32 lf rises, one period per 64 lf periods
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_q        <= DIV_RST;
      sample_clk_q <= 1'b0;
    end else if (!CFG.monitor_config_enable) begin
      div_q        <= DIV_RST;
      sample_clk_q <= 1'b0;
    end else if (lf_rise) begin
      if (div_q == DIV_LAST) begin // RULE1
        div_q        <= DIV_RST;
        sample_clk_q <= ~sample_clk_q;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // edges of the sample clock, seen in the cycle that toggles it
  assign samp_rise = CFG.monitor_config_enable & lf_rise & (div_q == DIV_LAST) & ~sample_clk_q;
  assign samp_fall = CFG.monitor_config_enable & lf_rise & (div_q == DIV_LAST) & sample_clk_q;

  // ==========================================================================
  // monitoring runs only on an external source after start-up is over
  assign sel_src      = scs_to_src(scs_q);
  assign start_masked = (state_q == FSC_ST_START); // RULE17 RULE18
  assign mon_active   = CFG.monitor_config_enable && (state_q == FSC_ST_RUN)
                        && (sel_src != FSC_SRC_INTERNAL); // RULE8 RULE16

  // monitor latch; a device edge in the same cycle as a sample rise wins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      latch_q <= 1'b0;
    end else if (!mon_active) begin
      latch_q <= 1'b0;
    end else if (dev_fall) begin
      latch_q <= 1'b1; // RULE2
    end else if (samp_rise) begin
      latch_q <= 1'b0; // RULE2
    end
  end

  // failure decided only on the sample fall
  assign fail_evt = mon_active & samp_fall & latch_q; // RULE3

  // ==========================================================================
  // source sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      FSC_ST_START: begin
        // a non-crystal primary without dual-speed needs no start-up masking
        if (PM.pm_entry) begin
          state_d = FSC_ST_RUN; // RULE13 RULE21
        end else if (!CFG.pri_is_crystal && !CFG.dual_speed_start_enable) begin
          state_d = FSC_ST_RUN; // RULE16
        end else if (PRI_READY) begin
          state_d = FSC_ST_RUN; // RULE11 RULE22
        end
      end
      FSC_ST_RUN: begin
        if (fail_evt) begin
          state_d = FSC_ST_FAILSAFE; // RULE5 RULE14
        end else if (PM.wake && (CFG.pri_is_crystal || CFG.dual_speed_start_enable)) begin
          state_d = FSC_ST_START; // RULE17 RULE22
        end
      end
      FSC_ST_FAILSAFE: begin
        // no automatic return to the failed source
        if (PM.pm_entry) begin
          state_d = FSC_ST_RUN; // RULE10 RULE13
        end
      end
      default: begin
        state_d = FSC_ST_START;
      end
    endcase
  end

  // reset always begins on the internal source, which is safe for any primary
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= FSC_ST_START; // RULE11
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // primary oscillator enable
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pri_en_q <= 1'b1; // RULE11
    end else if (state_q == FSC_ST_START && PM.pm_entry) begin
      pri_en_q <= (CTRL_WR.wr ? CTRL_WR.clock_source_select : scs_q) == SCS_PRIMARY; // RULE19
    end else if (PM.wake) begin
      pri_en_q <= 1'b1;
    end else if (PM.pm_entry) begin
      pri_en_q <= sel_src == FSC_SRC_PRIMARY;
    end
  end

  assign PRI_OSC_EN = pri_en_q;

  // ==========================================================================
  // osc control register fields; fail-safe never rewrites them
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scs_q <= SCS_RST; // RULE12
      ifs_q <= IFS_RST;
    end else if (CTRL_WR.wr) begin
      scs_q <= CTRL_WR.clock_source_select; // RULE21
      ifs_q <= CTRL_WR.internal_freq_select;
    end
  end

  // status reads 1 only while the primary really drives the device
  always_comb begin
    OSC_CTRL                      = '0;
    OSC_CTRL[SCS_LSB +: 2]        = scs_q; // RULE5
    OSC_CTRL[IFS_LSB +: 3]        = ifs_q;
    OSC_CTRL[PRIMARY_RUN_MODE_BIT]         = (CLK_SEL == FSC_SRC_PRIMARY); // RULE20
  end

  // ==========================================================================
  // clock mux; start-up and fail-safe both run from the internal block
  always_comb begin
    case (state_q)
      FSC_ST_RUN:      CLK_SEL = sel_src; // RULE13
      FSC_ST_START:    CLK_SEL = FSC_SRC_INTERNAL; // RULE11 RULE17
      FSC_ST_FAILSAFE: CLK_SEL = FSC_SRC_INTERNAL; // RULE5 RULE14
      default:         CLK_SEL = FSC_SRC_INTERNAL;
    endcase
  end

  // with the fail interrupt off, an idle wake still runs on the internal block
  assign EXEC_ON_INT = (state_q == FSC_ST_FAILSAFE) & (PM.idle | ~FAIL_IE | FAIL_IE); // RULE15
  assign FAIL_SAFE   = (state_q == FSC_ST_FAILSAFE);

  // ==========================================================================
  // sticky fail flag; a failure in the clearing cycle wins
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flag_q <= 1'b0;
    end else if (fail_evt) begin
      flag_q <= 1'b1; // RULE4 RULE23
    end else if (FLAG_CLR) begin
      flag_q <= 1'b0; // RULE23
    end
  end

  always_comb begin
    IRQ_FLAGS2               = '0;
    IRQ_FLAGS2[OSC_FAIL_BIT] = flag_q; // RULE4
  end

  // ==========================================================================
  // watchdog restart, registered one-cycle pulse
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wdt_rst_q <= 1'b0;
    end else begin
      wdt_rst_q <= fail_evt; // RULE6
    end
  end

  assign WDT_RST = wdt_rst_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  logic [DIV_W:0] rise_cnt_q;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rise_cnt_q <= '0;
    end else if (samp_rise || samp_fall || !CFG.monitor_config_enable) begin
      rise_cnt_q <= '0;
    end else if (lf_rise) begin
      rise_cnt_q <= rise_cnt_q + 1'b1;
    end
  end

  sample_divide_a: assert property ( // RULE1
    (samp_rise || samp_fall) |-> (rise_cnt_q == (DIV_W+1)'(LF_HALF_DIV - 1)) || $past(!RST_N)
    || $past(!CFG.monitor_config_enable))
    else $error("sample clock half period is not 32 lf edges");

  latch_set_a: assert property ( // RULE2
    (mon_active && dev_fall) ##1 mon_active |-> latch_q)
    else $error("monitor latch not set by device clock fall");

  fail_detect_a: assert property ( // RULE3
    (mon_active && samp_fall && latch_q) |=> (state_q == FSC_ST_FAILSAFE))
    else $error("set latch at sample fall did not enter fail-safe");

  fail_flag_a: assert property ( // RULE4
    fail_evt |=> IRQ_FLAGS2[OSC_FAIL_BIT])
    else $error("failure did not set the fail flag");

  scs_kept_a: assert property ( // RULE5
    fail_evt && !CTRL_WR.wr |=> (CLK_SEL == FSC_SRC_INTERNAL) && $stable(scs_q))
    else $error("failure changed control register or left source selected");

  wdt_pulse_a: assert property ( // RULE6
    fail_evt |=> WDT_RST ##1 !WDT_RST || fail_evt)
    else $error("watchdog restart pulse wrong");

  lf_enable_a: assert property ( // RULE7
    CFG.monitor_config_enable |-> LF_OSC_EN)
    else $error("low-freq osc stopped while monitoring");

  no_int_mon_a: assert property ( // RULE8
    (CLK_SEL == FSC_SRC_INTERNAL) |-> !fail_evt)
    else $error("failure declared on internal source");

  failsafe_hold_a: assert property ( // RULE10
    (state_q == FSC_ST_FAILSAFE) && !PM.pm_entry |=> (state_q == FSC_ST_FAILSAFE))
    else $error("fail-safe left without power-managed entry");

  status_bit_a: assert property ( // RULE20
    OSC_CTRL[PRIMARY_RUN_MODE_BIT] |-> (state_q == FSC_ST_RUN) && (scs_q == SCS_PRIMARY))
    else $error("primary status set while primary not clocking");

  flag_sticky_a: assert property ( // RULE23
    flag_q && !FLAG_CLR |=> flag_q)
    else $error("fail flag dropped without clear");

  cover_fail_c:     cover property (fail_evt);
  cover_recover_c:  cover property ((state_q == FSC_ST_FAILSAFE) ##1 (state_q == FSC_ST_RUN));
  cover_startup_c:  cover property ((state_q == FSC_ST_START) && PRI_READY);
  cover_pm_start_c: cover property ((state_q == FSC_ST_START) && PM.pm_entry);

endmodule : fsc_monitor

// ==== test/fsc_osc_model.sv ====
// oscillator source model on the far side of the clock monitor
`timescale 1ns/10ps
module fsc_osc_model #(
  parameter int HALF  = 3,   // system cycles per half period
  parameter int START = 40   // start-up cycles before ready
) (
  // clock
  input  wire logic CLK_SYS,
  // control from the design and the bench
  input  wire logic OSC_EN,
  input  wire logic RESTART,
  input  wire logic RUN_CLK,
  input  wire logic STARTS,
  // oscillator outputs
  output logic      DEV_CLK,
  output logic      PRI_READY
);
  int   ph_q  = 0;
  int   up_q  = 0;
  logic dev_q = 1'b0;

  // ==========================================================================
  // oscillation: a stopped source stands still, it makes no edges
  always @(posedge CLK_SYS) begin
    ph_q <= (ph_q == HALF - 1) ? 0 : ph_q + 1;
    if (RUN_CLK && ph_q == HALF - 1) begin
      dev_q <= !dev_q;
    end
  end
  assign DEV_CLK = dev_q;

  // ==========================================================================
  // start-up count: a wake restarts it, a disabled or dead source never gets ready
  always @(posedge CLK_SYS) begin
    if (!OSC_EN || RESTART || !STARTS) begin
      up_q <= 0;
    end else if (up_q < START) begin
      up_q <= up_q + 1;
    end
  end
  assign PRI_READY = (up_q == START);
endmodule : fsc_osc_model

// ==== test/fail_safe_clock_monitor_bench.sv ====
// self-checking bench for the clock failure monitor
`timescale 1ns/10ps
module fail_safe_clock_monitor_bench;
  import fsc_pkg::*;
  localparam int LF_CYC = 4;  // system cycles per lf osc period
  logic         clk_sys = 1'b0, rst_n = 1'b0, lf_osc = 1'b0;
  logic         flag_clr = 1'b0, fail_ie = 1'b1, wdt_en = 1'b0;
  logic         osc_run = 1'b0, osc_starts = 1'b0;
  logic         dev_clk, pri_ready, pri_osc_en, lf_osc_en, exec_on_int, fail_safe, wdt_rst;
  fsc_cfg_t     cfg = 3'b111;
  fsc_ctrl_wr_t ctrl_wr = '0;
  fsc_pm_t      pm = '0;
  fsc_src_t     clk_sel;
  logic [7:0]   osc_ctrl, irq_flags2;
  int           fail_count = 0, n_compared = 0, n;

  // ==========================================================================
  // clocks: the lf osc phase never meets a system edge
  initial begin
    forever #2.5 clk_sys = !clk_sys;
  end
  initial begin
    #1.25;
    forever #10 lf_osc = !lf_osc;
  end

  // ==========================================================================
  // design and far side
  fsc_monitor u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CFG(cfg), .LF_OSC(lf_osc),
    .DEV_CLK(dev_clk), .PRI_READY(pri_ready), .CTRL_WR(ctrl_wr), .FLAG_CLR(flag_clr),
    .FAIL_IE(fail_ie), .WDT_EN(wdt_en), .PM(pm), .CLK_SEL(clk_sel),
    .PRI_OSC_EN(pri_osc_en), .LF_OSC_EN(lf_osc_en), .EXEC_ON_INT(exec_on_int),
    .OSC_CTRL(osc_ctrl), .IRQ_FLAGS2(irq_flags2), .FAIL_SAFE(fail_safe), .WDT_RST(wdt_rst));
  fsc_osc_model u_osc (.CLK_SYS(clk_sys), .OSC_EN(pri_osc_en), .RESTART(pm.wake),
    .RUN_CLK(osc_run), .STARTS(osc_starts), .DEV_CLK(dev_clk), .PRI_READY(pri_ready));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // inputs always move 1 ns after the rising edge
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // bounded wait for fail-safe or for the primary to clock the device
  task automatic wait_for(input bit on_fs, input int lim, output int k);
    k = 0;
    while ((on_fs ? fail_safe : (clk_sel === FSC_SRC_PRIMARY)) !== 1'b1) begin
      step(1);
      k++;
      if (k > lim) begin
        fail_count++;
        $display("Error at %0t: wait ran out", $time);
        end_sim();
      end
    end
  endtask : wait_for

  task automatic do_reset(input fsc_cfg_t c);
    rst_n = 1'b0;
    cfg = c;
    step(3);
    rst_n = 1'b1;
    step(1);
  endtask : do_reset

  task automatic wr(input logic [1:0] scs, input logic [2:0] ifs);
    ctrl_wr = {1'b1, scs, ifs};
    step(1);
    ctrl_wr.wr = 1'b0;
  endtask : wr

  task automatic pm_pulse(input bit wake);
    pm.wake = wake;
    pm.pm_entry = !wake;
    step(1);
    pm.wake = 1'b0;
    pm.pm_entry = 1'b0;
  endtask : pm_pulse

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk(clk_sel, FSC_SRC_INTERNAL, "sel");
    chk(osc_ctrl, 8'h30, "ctrl");
    chk(irq_flags2, 8'h00, "flags");
    chk(pri_osc_en, 1'b1, "pri en");
    chk(wdt_rst, 1'b0, "wdt");
    $display("test reset done");
  endtask : t_reset

  // crystal that never starts: masked, no flag, register untouched
  task automatic t_no_start();
    osc_run = 1'b1;
    step(600);
    chk(clk_sel, FSC_SRC_INTERNAL, "sel");
    chk(osc_ctrl, 8'h30, "ctrl");
    chk(irq_flags2, 8'h00, "flags");
    chk(fail_safe, 1'b0, "fs");
    chk(lf_osc_en, 1'b1, "lf en");
    $display("test no start done");
  endtask : t_no_start

  task automatic t_start_ok();
    osc_run = 1'b0;
    osc_starts = 1'b1;
    wait_for(0, 100, n);
    chk(osc_ctrl, 8'h38, "ctrl");
    wr(SCS_PRIMARY, 3'h5);
    chk(osc_ctrl, 8'h58, "ctrl");
    $display("test start done");
  endtask : t_start_ok

  // the latch taken literally: a running monitored clock is declared failed
  task automatic t_fail();
    osc_run = 1'b1;
    wait_for(1, 600, n);
    chk(irq_flags2, 8'h80, "flags");
    chk(clk_sel, FSC_SRC_INTERNAL, "sel");
    chk(osc_ctrl, 8'h50, "ctrl");
    chk(wdt_rst, 1'b1, "wdt");
    chk(exec_on_int, 1'b1, "exec");
    step(1);
    chk(wdt_rst, 1'b0, "wdt");
    wr(SCS_SECONDARY, 3'h5);
    chk(osc_ctrl, 8'h51, "ctrl");
    step(300);
    chk(clk_sel, FSC_SRC_INTERNAL, "sel");
    chk(fail_safe, 1'b1, "fs");
    $display("test fail done");
  endtask : t_fail

  task automatic t_recover();
    pm_pulse(0);
    chk(fail_safe, 1'b0, "fs");
    chk(clk_sel, FSC_SRC_SECONDARY, "sel");
    chk(irq_flags2, 8'h80, "flags");
    wait_for(1, 600, n);
    fail_ie = 1'b0;
    pm.idle = 1'b1;
    pm_pulse(0);
    wait_for(1, 600, n);
    chk(16'(n + 1), 16'(LF_DIV_RATIO * LF_CYC), "period");
    chk(exec_on_int, 1'b1, "exec");
    flag_clr = 1'b1;
    step(1);
    flag_clr = 1'b0;
    chk(irq_flags2, 8'h00, "flags");
    pm.idle = 1'b0;
    fail_ie = 1'b1;
    $display("test recover done");
  endtask : t_recover

  // wake into dual-speed start, reselect and leave before the primary is ready
  task automatic t_wake_start();
    osc_run = 1'b0;
    pm_pulse(0);
    wr(SCS_PRIMARY, 3'h5);
    chk(clk_sel, FSC_SRC_PRIMARY, "sel");
    pm_pulse(1);
    chk(clk_sel, FSC_SRC_INTERNAL, "sel");
    chk(osc_ctrl, 8'h50, "ctrl");
    wr(SCS_SECONDARY, 3'h5);
    chk(osc_ctrl, 8'h51, "ctrl");
    pm_pulse(0);
    chk(pri_osc_en, 1'b0, "pri en");
    chk(clk_sel, FSC_SRC_SECONDARY, "sel");
    $display("test wake start done");
  endtask : t_wake_start

  // reset in mid-run, monitor off, then a plain external clock
  task automatic t_cfg();
    osc_run = 1'b1;
    do_reset(3'b000);
    chk(lf_osc_en, 1'b0, "lf en");
    wdt_en = 1'b1;
    step(1);
    chk(lf_osc_en, 1'b1, "lf en");
    wait_for(0, 100, n);
    step(600);
    chk(irq_flags2, 8'h00, "flags");
    osc_run = 1'b0;
    do_reset(3'b100);
    wait_for(0, 100, n);
    pm_pulse(1);
    chk(clk_sel, FSC_SRC_PRIMARY, "sel");
    osc_run = 1'b1;
    wait_for(1, 600, n);
    chk(irq_flags2, 8'h80, "flags");
    $display("test config done");
  endtask : t_cfg

  // ==========================================================================
  // main sequence
  initial begin
    do_reset(3'b111);
    t_reset();
    t_no_start();
    t_start_ok();
    t_fail();
    t_recover();
    t_wake_start();
    t_cfg();
    end_sim();
  end
endmodule : fail_safe_clock_monitor_bench
